//--- pkg/dr_consts.vh
// constants for the display rail sequencer: register map, field positions, timing
// assumes a single core clock; included by bare name from the sequencer logic file only
`ifndef DR_CONSTS_VH
`define DR_CONSTS_VH
// register offsets
`define DR_ADDR_FAULT 8'h04
`define DR_ADDR_ENABLE 8'h05
`define DR_ADDR_BST_OUT 8'h06
`define DR_ADDR_NEG_OUT 8'h08
`define DR_ADDR_POS_OUT 8'h09
`define DR_ADDR_BST_CTL 8'h0d
`define DR_ADDR_NEG_CTL 8'h0f
// reset values
`define DR_RST_ENABLE 8'h07
`define DR_RST_ZERO 8'h00
`define DR_RST_BST_CTL 8'h34
`define DR_RST_NEG_CTL 8'hda
// enable register fields
`define DR_EN_BST 0
`define DR_EN_NEG 1
`define DR_EN_POS 2
`define DR_EN_PULLDOWN_OFF 6
`define DR_EN_WMASK 8'h7f
// fault register fields
`define DR_FLT_OTP 0
`define DR_FLT_UV_BASE 1
// control register fields and forced reserved bits
`define DR_BST_PFM_OFF 3
`define DR_NEG_PFM_OFF 5
`define DR_BST_CTL_MASK 8'h3f
`define DR_NEG_CTL_SET 8'hc0
// pump duty clamp, half of a switching period on a 0..255 scale
`define DR_DUTY_HALF 8'h80
// timing
`define DR_CLK_HZ 40000000
`define DR_UV_TIME_US 100
`define DR_NEG_DELAY_MS 2
`define DR_UV_W 12
`define DR_NEG_W 17
`endif

//--- logic/dr_sync.v
// two flip-flop synchroniser for a group of independent level inputs
// assumes each bit is a slow level; bits are not coherent with each other
`timescale 1ns/100ps
module dr_sync #(
  parameter W = 16
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // levels
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_q;

  // first stage is read only by the second
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

//--- logic/dr_i2c.v
// i2c target: 7-bit address, register pointer byte, auto-increment data bytes
// assumes scl and sda already synchronised; clock at least 10x the bus rate
`timescale 1ns/100ps
module dr_i2c #(
  parameter [6:0] DEV_ADDR = 7'h2a // arbitrary bus address
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // synchronised bus lines
  input wire scl_s,
  input wire sda_s,
  output reg sda_oe,
  // register side
  output reg wr_stb,
  output reg rd_stb,
  output reg stop_stb,
  output reg [7:0] ptr_q,
  output reg [7:0] wr_addr_q,
  output reg [7:0] wdata_q,
  input wire [7:0] rdata
);
  localparam ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_AACK = 3'h2, ST_PTR = 3'h3;
  localparam ST_WACK = 3'h4, ST_WDAT = 3'h5, ST_RDAT = 3'h6, ST_RACK = 3'h7;
  reg scl_p, sda_p, rw_q;
  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start = scl_s & scl_p & sda_p & ~sda_s;
  wire stop = scl_s & scl_p & ~sda_p & sda_s;
  wire full = (cnt_q == 4'h8);

  ////////////////////////////////////////////////////////////////////////
  // bus state machine; sda only changes after scl falls
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_p <= 1'b1; sda_p <= 1'b1; rw_q <= 1'b0; st_q <= ST_IDLE;
      cnt_q <= 4'h0; sh_q <= 8'h00; sda_oe <= 1'b0; wr_stb <= 1'b0;
      rd_stb <= 1'b0; stop_stb <= 1'b0; ptr_q <= 8'h00;
      wr_addr_q <= 8'h00; wdata_q <= 8'h00;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      stop_stb <= 1'b0;
      if (start) begin
        st_q <= ST_ADDR; cnt_q <= 4'h0; sda_oe <= 1'b0;
      end else if (stop) begin
        st_q <= ST_IDLE; sda_oe <= 1'b0; stop_stb <= 1'b1;
      end else if (scl_rise) begin
        case (st_q)
          ST_ADDR, ST_PTR, ST_WDAT: begin
            sh_q <= {sh_q[6:0], sda_s}; cnt_q <= cnt_q + 4'h1;
          end
          ST_RDAT: cnt_q <= cnt_q + 4'h1;
          ST_RACK: if (sda_s) st_q <= ST_IDLE; // controller nack ends the read
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st_q)
          ST_ADDR: if (full) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              st_q <= ST_AACK; rw_q <= sh_q[0]; sda_oe <= 1'b1;
            end else st_q <= ST_IDLE;
          end
          ST_AACK, ST_RACK: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              sh_q <= rdata; rd_stb <= 1'b1; sda_oe <= ~rdata[7]; st_q <= ST_RDAT;
            end else begin
              sda_oe <= 1'b0; st_q <= ST_PTR;
            end
          end
          ST_PTR: if (full) begin
            ptr_q <= sh_q; sda_oe <= 1'b1; st_q <= ST_WACK;
          end
          ST_WDAT: if (full) begin
            wdata_q <= sh_q; wr_addr_q <= ptr_q; ptr_q <= ptr_q + 8'h01;
            wr_stb <= 1'b1; sda_oe <= 1'b1; st_q <= ST_WACK;
          end
          ST_WACK: begin
            sda_oe <= 1'b0; cnt_q <= 4'h0; st_q <= ST_WDAT;
          end
          ST_RDAT: if (full) begin
            sda_oe <= 1'b0; ptr_q <= ptr_q + 8'h01; st_q <= ST_RACK;
          end else begin
            sh_q <= {sh_q[6:0], 1'b0}; sda_oe <= ~sh_q[6];
          end
          default: ;
        endcase
      end
    end
  end
endmodule

//--- logic/dr_seq.v
// display rail sequencer: rail enables, start-up ordering, fault latching, i2c registers
// assumes rstn is the supply power-on reset and analog flags are asynchronous levels
// Functional notes
// - boost runs when a pin high and bit0
// - negative rail needs its pin and bit1
// - positive rail needs its pin and bit2
// - enable bits 2..0 reset to one
// - input lockout stops all rails, restart soft
// - registers kept through lockout, reset by power
// - over-temperature stops all rails, auto restart
// - over-temperature latches fault bit0 only
// - pin cycling or power cycling clears faults
// - second fault read clears over-temperature bit
// - no undervoltage detect during over-temperature
// - undervoltage must persist 100 us to latch
// - undervoltage bits 3,2,1 for pos,neg,boost
// - current limit ends switch cycle only
// - positive starts after boost soft-start done
// - negative starts 2 ms after later event
// - one pin drop stops own rail only
// - enable writes act at i2c stop
// - full enable write: positive, then negative
// - pulse skipping with hysteresis when enabled
// - pump duty clamped to half period
`timescale 1ns/100ps
`include "dr_consts.vh"
module dr_seq #(
  parameter [6:0] DEV_ADDR = 7'h2a, // arbitrary bus address
  parameter NEG_DELAY_CYC = (`DR_CLK_HZ / 1000) * `DR_NEG_DELAY_MS
) (
  // clock and power-on reset
  input wire core_clk,
  input wire rstn,
  // enable pins
  input wire positive_rail_enable_pin,
  input wire negative_rail_enable_pin,
  // i2c pins, open drain
  input wire i2c_scl,
  input wire i2c_sda_in,
  output wire i2c_sda_out,
  output wire i2c_sda_oe,
  // analog indications, asynchronous
  input wire input_lockout,
  input wire over_temp_flag,
  input wire [2:0] rail_undervoltage_flag,
  input wire boost_softstart_done,
  input wire switch_current_limit,
  input wire boost_pwm_on,
  input wire [1:0] light_load,
  input wire [1:0] heavy_load,
  // pump loop duty command, same clock
  input wire [7:0] pump_duty_cmd,
  // rail controls
  output reg boost_rail_en,
  output reg negative_pump_rail_en,
  output reg positive_linear_rail_en,
  output reg boost_switch_on,
  output reg [1:0] pulse_skipping_mode,
  output reg [7:0] pump_duty,
  // register contents for the analog side
  output wire positive_pulldown_off,
  output wire [4:0] boost_rail_code,
  output wire [4:0] negative_pump_rail_code,
  output wire [4:0] positive_linear_rail_code,
  output wire [7:0] boost_ctrl,
  output wire [7:0] pump_ctrl
);
  localparam integer UV_CYC_I = (`DR_CLK_HZ / 1000000) * `DR_UV_TIME_US;
  localparam [`DR_UV_W-1:0] UV_CYC = UV_CYC_I[`DR_UV_W-1:0];
  localparam [`DR_NEG_W-1:0] NEG_CYC = NEG_DELAY_CYC[`DR_NEG_W-1:0];

  wire [15:0] sync_v;
  wire enp_s, enn_s, scl_s, sda_s, lock_s, otp_s, ss_s, ilim_s, pwm_s;
  wire [2:0] uv_s;
  wire [1:0] light_s, heavy_s;
  wire wr_stb, rd_stb, stop_stb;
  wire [7:0] ptr, wr_addr, wdata;
  reg [7:0] rdata;
  reg [7:0] fault_q, ena_q, pend_q, bst_out_q, neg_out_q, pos_out_q, bst_ctl_q, neg_ctl_q;
  reg pend_v_q, otp_once_q, both_low_q, pwm_p_q, ilim_lat_q;
  reg [`DR_NEG_W-1:0] dly_q;
  wire [2:0] uv_hit;
  wire [2:0] rail_on;
  wire [1:0] pfm_allow;

  ////////////////////////////////////////////////////////////////////////
  // every pin and analog flag passes two flops before use
  dr_sync #(.W(16)) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .async_in({positive_rail_enable_pin, negative_rail_enable_pin, i2c_scl, i2c_sda_in,
      input_lockout, over_temp_flag, rail_undervoltage_flag, boost_softstart_done,
      switch_current_limit, boost_pwm_on, light_load, heavy_load}),
    .sync_out(sync_v)
  );
  assign {enp_s, enn_s, scl_s, sda_s, lock_s, otp_s, uv_s, ss_s, ilim_s, pwm_s,
    light_s, heavy_s} = sync_v;

  // bus target; sda only ever pulled low
  dr_i2c #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .core_clk(core_clk),
    .rstn(rstn),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .sda_oe(i2c_sda_oe),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .stop_stb(stop_stb),
    .ptr_q(ptr),
    .wr_addr_q(wr_addr),
    .wdata_q(wdata),
    .rdata(rdata)
  );
  assign i2c_sda_out = 1'b0;

  // register address match, shared by write and read paths
  function is_reg;
    input [7:0] a;
    input [7:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction

  wire wr_any = wr_stb;
  wire rd_fault = rd_stb & is_reg(ptr, `DR_ADDR_FAULT);
  // both pins seen low last cycle and high now counts as a simultaneous cycle
  wire pin_clear = both_low_q & enp_s & enn_s;
  wire otp_clear = pin_clear | (rd_fault & otp_once_q);

  ////////////////////////////////////////////////////////////////////////
  // read multiplexer; unmapped and reserved locations read zero
  always @* begin
    rdata = 8'h00;
    if (is_reg(ptr, `DR_ADDR_FAULT)) rdata = fault_q;
    else if (is_reg(ptr, `DR_ADDR_ENABLE)) rdata = ena_q;
    else if (is_reg(ptr, `DR_ADDR_BST_OUT)) rdata = bst_out_q;
    else if (is_reg(ptr, `DR_ADDR_NEG_OUT)) rdata = neg_out_q;
    else if (is_reg(ptr, `DR_ADDR_POS_OUT)) rdata = pos_out_q;
    else if (is_reg(ptr, `DR_ADDR_BST_CTL)) rdata = bst_ctl_q;
    else if (is_reg(ptr, `DR_ADDR_NEG_CTL)) rdata = neg_ctl_q;
  end

  // register file; only power-on reset clears it, lockout leaves it alone
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ena_q <= `DR_RST_ENABLE;
      pend_q <= `DR_RST_ZERO;
      pend_v_q <= 1'b0;
      bst_out_q <= `DR_RST_ZERO;
      neg_out_q <= `DR_RST_ZERO;
      pos_out_q <= `DR_RST_ZERO;
      bst_ctl_q <= `DR_RST_BST_CTL;
      neg_ctl_q <= `DR_RST_NEG_CTL;
    end else begin
      // the enable byte waits for stop so its bits act together
      if (wr_any && is_reg(wr_addr, `DR_ADDR_ENABLE)) begin
        pend_q <= wdata & `DR_EN_WMASK;
        pend_v_q <= 1'b1;
      end else if (stop_stb) begin
        pend_v_q <= 1'b0;
      end
      if (stop_stb && pend_v_q) ena_q <= pend_q;
      if (wr_any && is_reg(wr_addr, `DR_ADDR_BST_OUT)) bst_out_q <= wdata;
      if (wr_any && is_reg(wr_addr, `DR_ADDR_NEG_OUT)) neg_out_q <= wdata;
      if (wr_any && is_reg(wr_addr, `DR_ADDR_POS_OUT)) pos_out_q <= wdata;
      if (wr_any && is_reg(wr_addr, `DR_ADDR_BST_CTL))
        bst_ctl_q <= wdata & `DR_BST_CTL_MASK;
      if (wr_any && is_reg(wr_addr, `DR_ADDR_NEG_CTL))
        neg_ctl_q <= wdata | `DR_NEG_CTL_SET;
    end
  end

  assign positive_pulldown_off = ena_q[`DR_EN_PULLDOWN_OFF];
  assign boost_rail_code = bst_out_q[4:0];
  assign negative_pump_rail_code = neg_out_q[4:0];
  assign positive_linear_rail_code = pos_out_q[4:0];
  assign boost_ctrl = bst_ctl_q;
  assign pump_ctrl = neg_ctl_q;

  ////////////////////////////////////////////////////////////////////////
  // undervoltage filters: index 0 boost, 1 negative, 2 positive
  assign rail_on = {positive_linear_rail_en, negative_pump_rail_en, boost_rail_en};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_uv
      reg [`DR_UV_W-1:0] cnt_q;
      // any gap restarts the count, so short dips never latch
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) cnt_q <= {`DR_UV_W{1'b0}};
        else if (!uv_s[gi] || !rail_on[gi] || otp_s) cnt_q <= {`DR_UV_W{1'b0}};
        else if (cnt_q != UV_CYC) cnt_q <= cnt_q + 1'b1;
      end
      assign uv_hit[gi] = (cnt_q == UV_CYC) & ~otp_s;
    end
  endgenerate

  // fault latches; a new event wins over any clear in the same cycle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fault_q <= `DR_RST_ZERO;
      otp_once_q <= 1'b0;
      both_low_q <= 1'b0;
    end else begin
      both_low_q <= ~enp_s & ~enn_s;
      fault_q[`DR_FLT_OTP] <= otp_s | (fault_q[`DR_FLT_OTP] & ~otp_clear);
      fault_q[`DR_FLT_UV_BASE+2:`DR_FLT_UV_BASE] <= uv_hit |
        (fault_q[`DR_FLT_UV_BASE+2:`DR_FLT_UV_BASE] & {3{~pin_clear}});
      // first read of a latched bit arms, second clears
      if (!fault_q[`DR_FLT_OTP] || otp_clear) otp_once_q <= 1'b0;
      else if (rd_fault) otp_once_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // negative rail delay: restarts whenever soft-start or its request drops
  wire neg_req = enn_s & ena_q[`DR_EN_NEG];
  wire dly_done = (dly_q == NEG_CYC);
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) dly_q <= {`DR_NEG_W{1'b0}};
    else if (!(boost_rail_en && ss_s && neg_req)) dly_q <= {`DR_NEG_W{1'b0}};
    else if (!dly_done) dly_q <= dly_q + 1'b1;
  end

  // rail enables; lockout and over-temperature drop all at once
  wire rails_ok = ~lock_s & ~otp_s;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      boost_rail_en <= 1'b0;
      negative_pump_rail_en <= 1'b0;
      positive_linear_rail_en <= 1'b0;
    end else begin
      boost_rail_en <= rails_ok & (enp_s | enn_s) & ena_q[`DR_EN_BST] &
        ~fault_q[`DR_FLT_UV_BASE];
      positive_linear_rail_en <= rails_ok & boost_rail_en & ss_s & enp_s &
        ena_q[`DR_EN_POS] & ~fault_q[`DR_FLT_UV_BASE+2];
      negative_pump_rail_en <= rails_ok & boost_rail_en & dly_done & neg_req &
        ~fault_q[`DR_FLT_UV_BASE+1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // switch gate: the current limit cuts the rest of the cycle, never the rail
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pwm_p_q <= 1'b0;
      ilim_lat_q <= 1'b0;
      boost_switch_on <= 1'b0;
    end else begin
      pwm_p_q <= pwm_s;
      if (ilim_s) ilim_lat_q <= 1'b1;
      else if (pwm_s && !pwm_p_q) ilim_lat_q <= 1'b0;
      boost_switch_on <= boost_rail_en & pwm_s & ~ilim_s & ~ilim_lat_q;
    end
  end

  // pulse skipping: enter on light load, leave on heavy load, hold in between
  assign pfm_allow = {~neg_ctl_q[`DR_NEG_PFM_OFF] & negative_pump_rail_en,
    ~bst_ctl_q[`DR_BST_PFM_OFF] & boost_rail_en};
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pfm
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) pulse_skipping_mode[gi] <= 1'b0;
        else if (!pfm_allow[gi]) pulse_skipping_mode[gi] <= 1'b0;
        else if (light_s[gi]) pulse_skipping_mode[gi] <= 1'b1;
        else if (heavy_s[gi]) pulse_skipping_mode[gi] <= 1'b0;
      end
    end
  endgenerate

  // pump duty clamp; zero while the pump is off
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) pump_duty <= 8'h00;
    else if (!negative_pump_rail_en) pump_duty <= 8'h00;
    else if (pump_duty_cmd > `DR_DUTY_HALF) pump_duty <= `DR_DUTY_HALF;
    else pump_duty <= pump_duty_cmd;
  end
endmodule

//--- bench/dr_seq_properties.sv
// port-level checks for the display rail sequencer
// assumes one clock and an async active-low power-on reset
`timescale 1ns/100ps
module dr_seq_chk #(
  parameter NEG_DELAY_CYC = 80000
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // pins and indications
  input wire positive_rail_enable_pin,
  input wire negative_rail_enable_pin,
  input wire input_lockout,
  input wire over_temp_flag,
  input wire boost_softstart_done,
  input wire switch_current_limit,
  // rail controls
  input wire boost_rail_en,
  input wire negative_pump_rail_en,
  input wire positive_linear_rail_en,
  input wire boost_switch_on,
  input wire [7:0] pump_duty
);
  reg [31:0] rdy_q;
  wire any_rail = boost_rail_en | negative_pump_rail_en | positive_linear_rail_en;
  default clocking dr_cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
////////////////////////////////////////
  // run length of soft-start done with the negative pin high
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdy_q <= 32'h0;
    end else begin
      rdy_q <= (boost_softstart_done & negative_rail_enable_pin) ? rdy_q + 32'h1 : 32'h0;
    end
  end
////////////////////////////////////////
  // five clocks cover two sync flops and the output register
  chk_boost_gate: assert property (
    (!positive_rail_enable_pin && !negative_rail_enable_pin)[*5] |-> !boost_rail_en)
    else $error("boost on, pins low");
  chk_neg_gate: assert property (
    (!negative_rail_enable_pin)[*5] |-> !negative_pump_rail_en) else $error("neg on, pin low");
  chk_pos_gate: assert property (
    (!positive_rail_enable_pin)[*5] |-> !positive_linear_rail_en) else $error("pos on, pin low");
  chk_lockout_off: assert property (
    input_lockout[*5] |-> !any_rail) else $error("rail on in lockout");
  chk_hot_off: assert property (
    over_temp_flag[*5] |-> !any_rail) else $error("rail on while hot");
  chk_pos_after: assert property (
    positive_linear_rail_en |-> boost_rail_en) else $error("pos without boost");
  // the delay may only run while both of its causes stand
  chk_neg_delay: assert property (
    $rose(negative_pump_rail_en) |-> rdy_q >= NEG_DELAY_CYC) else $error("neg too early");
  chk_duty_clamp: assert property (
    pump_duty <= 8'h80) else $error("duty above half");
  chk_limit_cut: assert property (
    switch_current_limit[*5] |-> !boost_switch_on) else $error("switch on at limit");
  chk_switch_gate: assert property (
    boost_switch_on |-> boost_rail_en || $past(boost_rail_en)) else $error("switch, no boost");
endmodule
bind dr_seq dr_seq_chk #(.NEG_DELAY_CYC(NEG_DELAY_CYC)) u_chk (
  .core_clk, .rstn, .positive_rail_enable_pin, .negative_rail_enable_pin, .input_lockout,
  .over_temp_flag, .boost_softstart_done, .switch_current_limit, .boost_rail_en,
  .negative_pump_rail_en, .positive_linear_rail_en, .boost_switch_on, .pump_duty
);

//--- bench/dr_host_model.sv
// i2c host model for the sequencer register bus
// assumes an open-drain sda with a pull-up, paced by core_clk
`timescale 1ns/100ps
module dr_host_model #(
  parameter [6:0] ADDR = 7'h2a // arbitrary bus address
) (
  // clock and bus
  input wire core_clk,
  input wire dut_sda_oe,
  output reg scl,
  output wire sda,
  // missing acknowledges
  output reg [7:0] nacks
);
  reg drv_low = 1'b0;
  // a released line floats high through the pull-up
  assign sda = ~(drv_low | dut_sda_oe);
  initial begin
    scl = 1'b1;
    nacks = 8'h00;
  end
////////////////////////////////////////
  // six clocks a phase, above the five-clock minimum of the target
  task put(input c, input d);
    scl = c;
    drv_low = ~d;
    repeat (6) @(negedge core_clk);
  endtask
  // data held a phase past the fall so it never moves with scl
  task shift_bit(input b, output q);
    put(1'b0, b);
    scl = 1'b1;
    repeat (3) @(negedge core_clk);
    q = sda;
    repeat (3) @(negedge core_clk);
    put(1'b0, b);
  endtask
  task xbyte(input [7:0] w, input ck, output [7:0] q);
    reg a;
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      shift_bit(w[i], q[i]);
    end
    shift_bit(1'b1, a);
    if (ck && a) begin
      nacks = nacks + 8'h01;
    end
  endtask
  task start;
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
    put(1'b0, 1'b0);
  endtask
  task stop;
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
  endtask
  // one register byte per transaction, so separate writes act apart
  task wr(input [7:0] ra, input [7:0] w);
    reg [7:0] q;
    start;
    xbyte({ADDR, 1'b0}, 1'b1, q);
    xbyte(ra, 1'b1, q);
    xbyte(w, 1'b1, q);
    stop;
  endtask
  // pointer write, repeated start, one byte read and not acknowledged
  task rd(input [7:0] ra, output [7:0] w);
    reg [7:0] q;
    start;
    xbyte({ADDR, 1'b0}, 1'b1, q);
    xbyte(ra, 1'b1, q);
    start;
    xbyte({ADDR, 1'b1}, 1'b1, q);
    xbyte(8'hff, 1'b0, w);
    stop;
  endtask
endmodule

//--- bench/tb_display_rail_enable_fault_sequencer.sv
// self-checking bench for the display rail sequencer
// assumes the host model drives i2c and the checker is bound to dr_seq
`timescale 1ns/100ps
module tb_display_rail_enable_fault_sequencer;
  localparam NEG = 20;
  reg core_clk, rstn, pin_pos, pin_neg, lockout, hot, ss, limit, pwm;
  reg [2:0] uv;
  reg [1:0] light, heavy;
  reg [7:0] duty_cmd, d;
  reg [7:0] ra [5] = '{8'h04, 8'h05, 8'h0d, 8'h0f, 8'h01};
  reg [7:0] rv [5] = '{8'h00, 8'h07, 8'h34, 8'hda, 8'h00};
  reg [31:0] r;
  wire scl, sda, sda_oe, b_en, n_en, p_en, sw_on, pd_off;
  wire [1:0] psm;
  wire [7:0] duty, nacks, bctl, pctl;
  integer fails = 0, n_tests = 0, cyc = 0, i, n;
  dr_seq #(.NEG_DELAY_CYC(NEG)) dut (
    .core_clk(core_clk), .rstn(rstn), .positive_rail_enable_pin(pin_pos),
    .negative_rail_enable_pin(pin_neg), .i2c_scl(scl), .i2c_sda_in(sda), .i2c_sda_out(),
    .i2c_sda_oe(sda_oe), .input_lockout(lockout), .over_temp_flag(hot),
    .rail_undervoltage_flag(uv), .boost_softstart_done(ss), .switch_current_limit(limit),
    .boost_pwm_on(pwm), .light_load(light), .heavy_load(heavy), .pump_duty_cmd(duty_cmd),
    .boost_rail_en(b_en), .negative_pump_rail_en(n_en), .positive_linear_rail_en(p_en),
    .boost_switch_on(sw_on), .pulse_skipping_mode(psm), .pump_duty(duty),
    .positive_pulldown_off(pd_off), .boost_rail_code(), .negative_pump_rail_code(),
    .positive_linear_rail_code(), .boost_ctrl(bctl), .pump_ctrl(pctl));
  dr_host_model u_host (.core_clk(core_clk), .dut_sda_oe(sda_oe), .scl(scl), .sda(sda),
    .nacks(nacks));
////////////////////////////////////////
  // 40 MHz clock, and a ceiling about twice the expected run
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      fails = fails + 1;
      end_sim;
    end
  end
////////////////////////////////////////
  // helpers: expectations assume soft-start done and no fault latched
  function [2:0] exp_rails(input p, input q, input [2:0] e);
    exp_rails = {(p | q) & e[0] & p & e[2], (p | q) & e[0] & q & e[1], (p | q) & e[0]};
  endfunction
  function [7:0] exp_duty(input [7:0] c);
    exp_duty = (c > 8'h80) ? 8'h80 : c;
  endfunction
  task step(input integer k);
    repeat (k) @(negedge core_clk);
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for the negative rail, then its delay is judged
  task count_neg(input integer lo, input integer hi);
    n = 0;
    while (n_en !== 1'b1 && n < 300) begin
      step(1);
      n = n + 1;
    end
    chk(n >= lo && n <= hi, 1'b1);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
////////////////////////////////////////
  // main sequence, inputs change at falling edges only
  initial begin
    {rstn, pin_pos, pin_neg, lockout, hot, ss, limit, pwm} = 8'h00;
    {uv, light, heavy, duty_cmd} = 15'h0;
    r = $urandom(34);
    step(2);
    rstn = 1'b1;
    step(5);
    u_host.wr(8'h04, 8'hff);
    for (i = 0; i < 5; i = i + 1) begin
      u_host.rd(ra[i], d);
      chk(d, rv[i]);
    end
    {pin_pos, pin_neg} = 2'b11;
    step(8);
    chk({p_en, n_en, b_en}, 3'b001);
    ss = 1'b1;
    step(6);
    chk({p_en, n_en, b_en}, 3'b101);
    count_neg(NEG - 6, NEG + 6);
    u_host.wr(8'h05, 8'h00);
    step(6);
    chk({p_en, n_en, b_en}, 3'b000);
    u_host.wr(8'h05, 8'h07);
    step(6);
    chk({p_en, n_en, b_en}, 3'b101);
    count_neg(NEG - 14, NEG + 4);
    $display("test sequencing done");
    for (i = 0; i < 12; i = i + 1) begin
      r = (i == 0) ? 32'h03 : (i == 1) ? 32'h1e : (i == 2) ? 32'h05 : $urandom;
      u_host.wr(8'h05, {5'h00, r[4:2]});
      {pin_pos, pin_neg} = r[1:0];
      step(NEG + 12);
      chk({p_en, n_en, b_en}, exp_rails(r[1], r[0], r[4:2]));
    end
    u_host.wr(8'h05, 8'h47);
    {pin_pos, pin_neg} = 2'b11;
    step(NEG + 12);
    chk({pd_off, p_en, n_en, b_en}, 4'hf);
    lockout = 1'b1;
    step(6);
    chk({p_en, n_en, b_en}, 3'b000);
    lockout = 1'b0;
    step(NEG + 12);
    chk({p_en, n_en, b_en}, 3'b111);
    u_host.rd(8'h05, d);
    chk(d, 8'h47);
    $display("test gating done");
    hot = 1'b1;
    step(6);
    chk({p_en, n_en, b_en}, 3'b000);
    uv = 3'h7;
    step(4100);
    uv = 3'h0;
    u_host.rd(8'h04, d);
    chk(d, 8'h01);
    hot = 1'b0;
    step(NEG + 12);
    chk({p_en, n_en, b_en}, 3'b111);
    u_host.rd(8'h04, d);
    chk(d, 8'h01);
    u_host.rd(8'h04, d);
    chk(d, 8'h00);
    uv[2] = 1'b1;
    step(3990);
    uv[2] = 1'b0;
    step(6);
    chk(p_en, 1'b1);
    for (i = 2; i >= 0; i = i - 1) begin
      uv[i] = 1'b1;
      step(4010);
      uv[i] = 1'b0;
      u_host.rd(8'h04, d);
      chk(d, 8'h10 - (8'h02 << i));
      chk({p_en, n_en, b_en}, 3'b111 >> (3 - i));
    end
    {pin_pos, pin_neg} = 2'b00;
    step(4);
    {pin_pos, pin_neg} = 2'b11;
    step(NEG + 12);
    u_host.rd(8'h04, d);
    chk(d, 8'h00);
    chk({p_en, n_en, b_en}, 3'b111);
    $display("test faults done");
    pwm = 1'b1;
    step(6);
    limit = 1'b1;
    step(6);
    chk({sw_on, p_en, n_en, b_en}, 4'h7);
    limit = 1'b0;
    step(6);
    chk(sw_on, 1'b0);
    pwm = 1'b0;
    step(4);
    pwm = 1'b1;
    step(6);
    chk(sw_on, 1'b1);
    light = 2'h3;
    step(6);
    light = 2'h0;
    step(6);
    chk(psm, 2'h3);
    heavy = 2'h3;
    step(6);
    chk(psm, 2'h0);
    heavy = 2'h0;
    u_host.wr(8'h0d, 8'h3c);
    light = 2'h3;
    step(6);
    chk(psm, 2'h2);
    chk(bctl, 8'h3c);
    chk(pctl, 8'hda);
    for (i = 0; i < 10; i = i + 1) begin
      duty_cmd = (i == 0) ? 8'h80 : (i == 1) ? 8'h81 : $urandom;
      step(2);
      chk(duty, exp_duty(duty_cmd));
    end
    chk(nacks, 8'h00);
    $display("test switching done");
    end_sim;
  end
endmodule
